// ### verilog/duhp_defs.svh
/*
 * Timing counts and field positions for the dual channel host bus port master.
 * Assumes a 40 MHz clock_i (25 ns period); included by bare name.
 */
`ifndef DUHP_DEFS_SVH
`define DUHP_DEFS_SVH

// ============================================================
// Timing (ns, then cycles derived at 25 ns per cycle)
// ============================================================
`define DUHP_CLK_PERIOD_NS 25
`define DUHP_ADDR_SETUP_NS 25
`define DUHP_STROBE_NS 100
`define DUHP_RECOVERY_NS 50
// Least times round up
`define DUHP_ADDR_SETUP_CYC ((`DUHP_ADDR_SETUP_NS + `DUHP_CLK_PERIOD_NS - 1) / `DUHP_CLK_PERIOD_NS)
`define DUHP_STROBE_CYC ((`DUHP_STROBE_NS + `DUHP_CLK_PERIOD_NS - 1) / `DUHP_CLK_PERIOD_NS)
`define DUHP_RECOVERY_CYC ((`DUHP_RECOVERY_NS + `DUHP_CLK_PERIOD_NS - 1) / `DUHP_CLK_PERIOD_NS)

// ============================================================
// Register indices and fields seen by the host
// ============================================================
`define DUHP_MODEM_CONTROL_IDX 3'h4
`define DUHP_MCR_IRQ_EN_BIT 3

`endif

// ### verilog/duhp_pkg.sv
/*
 * Types for the dual channel host bus port master.
 * Assumes duhp_defs.svh supplies the numeric constants.
 */
package duhp_pkg;
    // Bus cycle sequencer states
    typedef enum logic [2:0] {
        DUHP_IDLE,
        DUHP_SETUP,
        DUHP_STROBE,
        DUHP_HOLD,
        DUHP_RECOVER
    } duhp_state_t;
endpackage : duhp_pkg

// ### verilog/duhp_host.sv
/*
 * Host side master for a two channel parallel register port: it turns a
 * one-cycle request into a select, address, strobe and data bus cycle.
 * Assumes the device pins are asynchronous, so every device output is passed
 * through two flip-flops before use; the data bus is resolved outside.
 */
// Notes on behaviour
// - Eight-bit two-way data bus: device drives on reads, host on writes.
// - Read strobe falling starts read; host keeps the data it sampled one clock before the strobe rising edge.
// - Write strobe falling starts write; device stores data at rising edge.
// - Host holds first channel select low through the whole of a first channel access.
// - Host holds second channel select low through the whole of a second channel access.
`timescale 1ns/1ps
`include "duhp_defs.svh"

module duhp_host (
    input wire logic clock_i, // 40 MHz clock
    input wire logic rst_n_i, // Asynchronous reset, active low
    input wire logic req_valid_i, // One-cycle access request
    input wire logic req_write_i, // 1 write, 0 read
    input wire logic req_chan_i, // 0 first channel, 1 second
    input wire logic [2:0] req_addr_i, // Register index
    input wire logic [7:0] req_wdata_i, // Write byte
    output logic req_ready_o, // Sequencer idle
    output logic done_o, // One-cycle access complete pulse
    output logic [7:0] rdata_o, // Last byte read
    output logic reg_select_bit2_o, // Register select lines
    output logic reg_select_bit1_o, // Register select
    output logic reg_select_bit0_o, // Register select
    input wire logic [7:0] bus_byte_i, // Data bus as seen on the wire
    output logic [7:0] bus_byte_o, // Data bus drive value
    output logic bus_byte_oe_n_o, // Low while host drives data bus
    output logic host_read_strobe_n_o, // Read strobe, active low
    output logic host_write_strobe_n_o, // Write strobe, active low
    output logic chan_first_select_n_o, // First channel select, active low
    output logic chan_second_select_n_o, // Second channel select, active low
    input wire logic chan_first_tx_ready_n_i, // Device transmit ready A
    input wire logic chan_first_rx_ready_n_i, // Device receive ready A
    input wire logic chan_second_tx_ready_n_i, // Device transmit ready B
    input wire logic chan_second_rx_ready_n_i, // Device receive ready B
    output logic [1:0] tx_ready_o, // Synchronised transmit ready, high active
    output logic [1:0] rx_ready_o, // Synchronised receive ready, high active
    output logic [1:0] irq_enable_o // Host shadow of modem control bit 3
);

    // ============================================================
    // Timing constants
    // ============================================================
    localparam logic [3:0] SETUP_CYC = 4'(`DUHP_ADDR_SETUP_CYC);
    localparam logic [3:0] STROBE_CYC = 4'(`DUHP_STROBE_CYC);
    localparam logic [3:0] RECOVERY_CYC = 4'(`DUHP_RECOVERY_CYC);

    duhp_pkg::duhp_state_t state;
    duhp_pkg::duhp_state_t next_state;
    logic [3:0] count;
    logic [3:0] next_count;
    logic write_op;
    logic chan_op;
    logic [2:0] addr_op;
    logic [7:0] wdata_op;
    logic [7:0] data_meta;
    logic [7:0] data_sync;
    logic [3:0] status_meta;
    logic [3:0] status_sync;

    // ============================================================
    // Status and data synchronisers
    // ============================================================
    // Device pins are asynchronous to clock_i; two stages each
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_meta <= 4'hf;
            status_sync <= 4'hf;
            data_meta <= 8'h00;
            data_sync <= 8'h00;
        end else begin
            status_meta <= {chan_second_rx_ready_n_i, chan_second_tx_ready_n_i,
                            chan_first_rx_ready_n_i, chan_first_tx_ready_n_i};
            status_sync <= status_meta;
            data_meta <= bus_byte_i;
            data_sync <= data_meta;
        end
    end

    // Ready pins are low active; present them high active
    assign tx_ready_o = {~status_sync[2], ~status_sync[0]};
    assign rx_ready_o = {~status_sync[3], ~status_sync[1]};

    // ============================================================
    // Bus cycle sequencer
    // ============================================================
    wire count_done = (count == 4'h0);
    wire in_access = (state != duhp_pkg::DUHP_IDLE) && (state != duhp_pkg::DUHP_RECOVER);
    wire strobe_on = (state == duhp_pkg::DUHP_STROBE);

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            duhp_pkg::DUHP_IDLE: begin
                if (req_valid_i) begin
                    next_state = duhp_pkg::DUHP_SETUP;
                    next_count = SETUP_CYC - 4'h1;
                end
            end
            duhp_pkg::DUHP_SETUP: begin
                next_count = count - 4'h1;
                if (count_done) begin
                    next_state = duhp_pkg::DUHP_STROBE;
                    next_count = STROBE_CYC - 4'h1;
                end
            end
            duhp_pkg::DUHP_STROBE: begin
                next_count = count - 4'h1;
                if (count_done) begin
                    next_state = duhp_pkg::DUHP_HOLD;
                end
            end
            duhp_pkg::DUHP_HOLD: begin
                // Strobe rose last edge; select and address still held
                next_state = duhp_pkg::DUHP_RECOVER;
                next_count = RECOVERY_CYC - 4'h1;
            end
            duhp_pkg::DUHP_RECOVER: begin
                next_count = count - 4'h1;
                if (count_done) begin
                    next_state = duhp_pkg::DUHP_IDLE;
                end
            end
            default: begin
                next_state = duhp_pkg::DUHP_IDLE;
                next_count = 4'h0;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= duhp_pkg::DUHP_IDLE;
            count <= 4'h0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Latch request fields so the pins stay steady for the whole access
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_op <= 1'b0;
            chan_op <= 1'b0;
            addr_op <= 3'h0;
            wdata_op <= 8'h00;
        end else if (state == duhp_pkg::DUHP_IDLE && req_valid_i) begin
            write_op <= req_write_i;
            chan_op <= req_chan_i;
            addr_op <= req_addr_i;
            wdata_op <= req_wdata_i;
        end
    end

    // ============================================================
    // Pin drive
    // ============================================================
    assign req_ready_o = (state == duhp_pkg::DUHP_IDLE);
    assign {reg_select_bit2_o, reg_select_bit1_o, reg_select_bit0_o} = addr_op;
    assign chan_first_select_n_o = ~(in_access && !chan_op);
    assign chan_second_select_n_o = ~(in_access && chan_op);
    assign host_read_strobe_n_o = ~(strobe_on && !write_op);
    assign host_write_strobe_n_o = ~(strobe_on && write_op);
    // Drive only on writes, and only while a select is low, so the device
    // never fights us and the bus floats between accesses
    assign bus_byte_oe_n_o = ~(in_access && write_op);
    assign bus_byte_o = wdata_op;

    // Load read data a cycle after the strobe rises; through the two stages it is the bus
    // of one cycle before the rise, which the strobe width covers since data is stable well before that edge
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= (state == duhp_pkg::DUHP_HOLD);
            if (state == duhp_pkg::DUHP_HOLD && !write_op) begin
                rdata_o <= data_sync;
            end
        end
    end

    // Track modem control bit 3 written per channel; device resets it to 0
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_enable_o <= 2'b00;
        end else if (state == duhp_pkg::DUHP_HOLD && write_op
                     && addr_op == `DUHP_MODEM_CONTROL_IDX) begin
            irq_enable_o[chan_op] <= wdata_op[`DUHP_MCR_IRQ_EN_BIT];
        end
    end

    // ============================================================
    // Assertions
    // ============================================================
    property p_one_select;
        @(posedge clock_i) disable iff (!rst_n_i)
        !(chan_first_select_n_o == 1'b0 && chan_second_select_n_o == 1'b0);
    endproperty
    a_one_select: assert property (p_one_select)
        else $error("both selects low");

    property p_strobe_in_select;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!host_read_strobe_n_o || !host_write_strobe_n_o)
            |-> (!chan_first_select_n_o || !chan_second_select_n_o);
    endproperty
    a_strobe_in_select: assert property (p_strobe_in_select)
        else $error("strobe without select");

    property p_strobe_width;
        @(posedge clock_i) disable iff (!rst_n_i)
        $fell(host_read_strobe_n_o) |-> !host_read_strobe_n_o[*4] ##1 host_read_strobe_n_o;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("read strobe width wrong");

    property p_write_width;
        @(posedge clock_i) disable iff (!rst_n_i)
        $fell(host_write_strobe_n_o) |-> !host_write_strobe_n_o[*4] ##1 host_write_strobe_n_o;
    endproperty
    a_write_width: assert property (p_write_width)
        else $error("write strobe width wrong");

    property p_no_drive_on_read;
        @(posedge clock_i) disable iff (!rst_n_i)
        !host_read_strobe_n_o |-> bus_byte_oe_n_o;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read)
        else $error("host drives on read");

    property p_float_idle;
        @(posedge clock_i) disable iff (!rst_n_i)
        (chan_first_select_n_o && chan_second_select_n_o) |-> bus_byte_oe_n_o;
    endproperty
    a_float_idle: assert property (p_float_idle)
        else $error("bus driven with no select");

    // Watch the pins themselves, not the latch behind them
    property p_addr_stable;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!host_read_strobe_n_o || !host_write_strobe_n_o)
            |=> $stable({reg_select_bit2_o, reg_select_bit1_o, reg_select_bit0_o}) || done_o;
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved under strobe");

    property p_done_after_rise;
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(host_write_strobe_n_o) |=> done_o;
    endproperty
    a_done_after_rise: assert property (p_done_after_rise)
        else $error("done late after write");

endmodule : duhp_host

// ### verif/duhp_dev_model.sv
/* Behavioural two channel register device for the host port bench.
   Assumes the bench resolves the data bus from the host output enable. */
`timescale 1ns/1ps
`include "duhp_defs.svh"
module duhp_dev_model (
    input wire logic rst_n_i, // Device reset, active low
    input wire logic slow_i, // Late read data
    input wire logic [2:0] addr_i, // Register select lines
    input wire logic [7:0] bus_i, // Data bus wire level
    output logic [7:0] bus_o, // Data bus value when host is off
    input wire logic rd_n_i, // Read strobe
    input wire logic wr_n_i, // Write strobe
    input wire logic cs_a_n_i, // First channel select
    input wire logic cs_b_n_i, // Second channel select
    input wire logic [1:0] tx_st_i, // Transmit status per channel
    input wire logic [1:0] rx_st_i, // Receive status per channel
    output logic [1:0] tx_ready_n_o, // Transmit ready, active low
    output logic [1:0] rx_ready_n_o, // Receive ready, active low
    output wire logic [1:0] irq_out_o, // Interrupt lines
    output logic [1:0] user_out2_n_o // User output 2, active low
);
    // ==========================================
    // Register store
    // ==========================================
    logic [7:0] regs [2][8];
    wire sel = !cs_a_n_i || !cs_b_n_i;
    wire ch = cs_a_n_i;
    // Stores land on the rising strobe edge only
    always @(posedge wr_n_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 16; i++) begin
                regs[i / 8][i % 8] = 8'h00;
            end
        end else if (sel) begin
            regs[ch][addr_i] = bus_i;
        end
    end
    // Data may come late; a released bus shows the inverse so stale data never passes
    initial bus_o = 8'h00;
    always @(negedge rd_n_i) begin
        if (sel) begin
            #(slow_i ? 40 : 5);
            bus_o = regs[ch][addr_i];
        end
    end
    always @(posedge rd_n_i) begin
        #3;
        bus_o = ~bus_o;
    end
    // ==========================================
    // Status pins
    // ==========================================
    for (genvar c = 0; c < 2; c++) begin : g_ch
        wire en = regs[c][`DUHP_MODEM_CONTROL_IDX][`DUHP_MCR_IRQ_EN_BIT];
        assign irq_out_o[c] = en ? 1'b0 : 1'bz;
        assign user_out2_n_o[c] = !en;
    end
    assign tx_ready_n_o = ~tx_st_i;
    assign rx_ready_n_o = ~rx_st_i;
endmodule : duhp_dev_model

// ### verif/duhp_host_test.sv
/* Self-checking bench for duhp_host driving the device model.
   Assumes a 40 MHz clock and the fixed access timing of the hand-over. */
`timescale 1ns/1ps
`include "duhp_defs.svh"
module duhp_host_test;
    logic clock_i = 1'b0;
    logic rst_n_i;
    logic req_valid = 1'b0, req_write = 1'b0, req_chan = 1'b0, slow = 1'b0;
    logic [2:0] req_addr = 3'h0;
    logic [7:0] req_wdata = 8'h00;
    logic [1:0] tx_st = 2'h0, rx_st = 2'h0;
    logic req_ready, done, a2, a1, a0, oe_n, rd_n, wr_n, cs_a_n, cs_b_n;
    logic [7:0] rdata, host_d, dev_d;
    logic [1:0] tx_rdy, rx_rdy, irq_en, tx_n, rx_n, out2_n;
    wire [1:0] irq_line;
    wire [7:0] bus = oe_n ? dev_d : host_d;
    int fail_count = 0, n_checks = 0;
    logic [7:0] mem [2][8];
    always #12.5 clock_i = ~clock_i;
    duhp_host duhp_host_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid),
        .req_write_i(req_write), .req_chan_i(req_chan), .req_addr_i(req_addr),
        .req_wdata_i(req_wdata), .req_ready_o(req_ready), .done_o(done), .rdata_o(rdata),
        .reg_select_bit2_o(a2), .reg_select_bit1_o(a1), .reg_select_bit0_o(a0),
        .bus_byte_i(bus), .bus_byte_o(host_d), .bus_byte_oe_n_o(oe_n),
        .host_read_strobe_n_o(rd_n), .host_write_strobe_n_o(wr_n),
        .chan_first_select_n_o(cs_a_n), .chan_second_select_n_o(cs_b_n),
        .chan_first_tx_ready_n_i(tx_n[0]), .chan_first_rx_ready_n_i(rx_n[0]),
        .chan_second_tx_ready_n_i(tx_n[1]), .chan_second_rx_ready_n_i(rx_n[1]),
        .tx_ready_o(tx_rdy), .rx_ready_o(rx_rdy), .irq_enable_o(irq_en));
    duhp_dev_model duhp_dev_model_inst (.rst_n_i(rst_n_i), .slow_i(slow),
        .addr_i({a2, a1, a0}), .bus_i(bus), .bus_o(dev_d), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .cs_a_n_i(cs_a_n), .cs_b_n_i(cs_b_n), .tx_st_i(tx_st), .rx_st_i(rx_st),
        .tx_ready_n_o(tx_n), .rx_ready_n_o(rx_n), .irq_out_o(irq_line),
        .user_out2_n_o(out2_n));
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One access; a stray request mid-access must be ignored
    task automatic access(input logic wr, input logic ch, input logic [2:0] a,
                          input logic [7:0] d, input bit inject);
        int n, lo, bad;
        lo = 0;
        bad = 0;
        @(posedge clock_i);
        req_valid <= 1'b1;
        req_write <= wr;
        req_chan <= ch;
        req_addr <= a;
        req_wdata <= d;
        #1;
        for (n = 0; req_ready !== 1'b1 && n < 20; n++) begin
            @(posedge clock_i);
            #1;
        end
        @(posedge clock_i);
        req_valid <= 1'b0;
        for (n = 1; n < 20; n++) begin
            @(posedge clock_i);
            req_valid <= inject && n == 2;
            req_chan <= !ch;
            req_write <= 1'b1;
            req_wdata <= ~d;
            #1;
            if ((wr ? wr_n : rd_n) === 1'b0) begin
                lo++;
            end
            if ((ch ? cs_b_n : cs_a_n) !== 1'b0 && (rd_n & wr_n) !== 1'b1) begin
                bad++;
            end
            if ((ch ? cs_a_n : cs_b_n) !== 1'b1 || (wr ? rd_n : wr_n) !== 1'b1) begin
                bad++;
            end
            if (done === 1'b1) begin
                break;
            end
        end
        // Done is seen just after the sixth edge past the taking edge
        chk("done delay", 8'h06, 8'(n));
        chk("strobe cycles", 8'h04, 8'(lo));
        chk("pin faults", 8'h00, 8'(bad));
        if (wr) begin
            mem[ch][a] = d;
        end else begin
            chk("read data", mem[ch][a], rdata);
        end
    endtask : access
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic test_reset();
        chk("idle pins", 8'h1f, {3'h0, cs_a_n, cs_b_n, rd_n, wr_n, oe_n});
        chk("reset outputs", 8'h00,
            {rdata | {7'h0, done} | {6'h0, irq_en} | {6'h0, tx_rdy | rx_rdy}});
        chk("out2 at reset", 8'h03, {6'h0, out2_n});
        $display("test reset done");
    endtask : test_reset
    task automatic test_regs();
        for (int i = 0; i < 16; i++) begin
            access(1'b1, i[3], i[2:0], {i[3:0], 4'ha} ^ 8'h36, 1'b0);
        end
        for (int i = 0; i < 16; i++) begin
            slow = i[3];
            access(1'b0, i[3], i[2:0], 8'h00, 1'b0);
        end
        $display("test registers done");
    endtask : test_regs
    task automatic test_irq();
        for (int i = 0; i < 4; i++) begin
            access(1'b1, i[1], `DUHP_MODEM_CONTROL_IDX, {4'h0, !i[0], 3'h5}, 1'b0);
            @(posedge clock_i);
            #1;
            chk("irq enable", {7'h0, !i[0]}, {7'h0, irq_en[i[1]]});
            chk("out2", {7'h0, i[0]}, {7'h0, out2_n[i[1]]});
            chk("irq line", {7'h0, i[0] ? 1'bz : 1'b0}, {7'h0, irq_line[i[1]]});
        end
        $display("test irq done");
    endtask : test_irq
    task automatic test_ready();
        for (int s = 0; s < 4; s++) begin
            @(posedge clock_i);
            tx_st <= s[1:0];
            rx_st <= ~s[1:0];
            repeat (3) @(posedge clock_i);
            #1;
            chk("tx ready", {6'h0, s[1:0]}, {6'h0, tx_rdy});
            chk("rx ready", {6'h0, ~s[1:0]}, {6'h0, rx_rdy});
        end
        $display("test ready done");
    endtask : test_ready
    task automatic test_refuse();
        access(1'b1, 1'b0, 3'h7, 8'hc3, 1'b1);
        access(1'b0, 1'b1, 3'h7, 8'h00, 1'b0);
        access(1'b0, 1'b0, 3'h7, 8'h00, 1'b0);
        $display("test refuse done");
    endtask : test_refuse
    // Reset in mid-run must clear both interrupt enables and resume cleanly
    task automatic test_midreset();
        access(1'b1, 1'b0, `DUHP_MODEM_CONTROL_IDX, 8'h08, 1'b0);
        access(1'b1, 1'b1, `DUHP_MODEM_CONTROL_IDX, 8'h08, 1'b0);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk("irq enable after reset", 8'h00, {6'h0, irq_en});
        chk("out2 after reset", 8'h03, {6'h0, out2_n});
        chk("irq line after reset", {6'h0, 2'bzz}, {6'h0, irq_line});
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            mem[i / 8][i % 8] = 8'h00;
        end
        access(1'b0, 1'b0, `DUHP_MODEM_CONTROL_IDX, 8'h00, 1'b0);
        access(1'b0, 1'b1, `DUHP_MODEM_CONTROL_IDX, 8'h00, 1'b0);
        $display("test mid-run reset done");
    endtask : test_midreset
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // Hang guard, far beyond the few hundred cycles of the run
    initial begin
        #200000;
        fail_count++;
        $display("watchdog expired");
        complete_run();
    end
    // Reset goes low at time zero so every async reset branch sees an edge
    initial begin
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        test_reset();
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        test_regs();
        test_irq();
        test_ready();
        test_refuse();
        test_midreset();
        complete_run();
    end
endmodule : duhp_host_test
